// ---- logic/lcd_irq_pkg.sv ----
package lcd_irq_pkg;

    // ========================================
    // bus widths
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned EVT_W  = 7;

    // ========================================
    // register byte addresses
    localparam logic [ADDR_W-1:0] IRQ_MASK_SET_ADDR      = 32'h0060_0848;
    localparam logic [ADDR_W-1:0] IRQ_MASK_CLEAR_ADDR    = 32'h0060_084c;
    localparam logic [ADDR_W-1:0] IRQ_MASK_VIEW_ADDR     = 32'h0060_0850;
    localparam logic [ADDR_W-1:0] IRQ_PENDING_ADDR       = 32'h0060_0854;
    localparam logic [ADDR_W-1:0] IRQ_PENDING_CLEAR_ADDR = 32'h0060_0858;

    // ========================================
    // event bit positions, shared by all five registers
    localparam int unsigned LINE_EVT_BIT      = 0;
    localparam int unsigned LAST_LINE_EVT_BIT = 1;
    localparam int unsigned FRAME_END_BIT     = 2;
    localparam int unsigned FIFO_UNDER_BIT    = 4;
    localparam int unsigned FIFO_OVERWR_BIT   = 5;
    localparam int unsigned FETCH_ERR_BIT     = 6;

    // implemented bits; bit 3 and bits 7 up are reserved
    localparam logic [EVT_W-1:0] EVT_FIELD_MASK = 7'h77;

    // ========================================
    // values after reset
    localparam logic [EVT_W-1:0]  MASK_RESET    = 7'h00;
    localparam logic [EVT_W-1:0]  PENDING_RESET = 7'h00;
    localparam logic [DATA_W-1:0] RDATA_RESET   = 32'h0000_0000;

endpackage

// ---- logic/lcd_irq_regs.sv ----
// Our own choice: the APB slave port.
`timescale 1ns/1ps

module lcd_irq_regs (
    input  wire logic                         i_clk,
    input  wire logic                         i_resetn,
    input  wire logic                         i_psel,
    input  wire logic                         i_penable,
    input  wire logic                         i_pwrite,
    input  wire logic [lcd_irq_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [lcd_irq_pkg::DATA_W-1:0] i_pwdata,
    input  wire logic [3:0]                   i_pstrb,
    output logic                              o_pready,
    output logic [lcd_irq_pkg::DATA_W-1:0]    o_prdata,
    output logic                              o_pslverr,
    input  wire logic                         i_line_evt,
    input  wire logic                         i_last_line_evt,
    input  wire logic                         i_frame_end,
    input  wire logic                         i_fifo_under,
    input  wire logic                         i_fifo_overwr,
    input  wire logic                         i_fetch_err,
    output logic                              o_irq
);
    import lcd_irq_pkg::*;

    // ========================================
    // field extraction

    // keep only implemented event bits of a word
    function automatic logic [EVT_W-1:0] evt_field(input logic [DATA_W-1:0] word);
        evt_field = word[EVT_W-1:0] & EVT_FIELD_MASK;
    endfunction

    // widen an event field to a bus word
    function automatic logic [DATA_W-1:0] to_word(input logic [EVT_W-1:0] field);
        to_word = {{(DATA_W-EVT_W){1'b0}}, field & EVT_FIELD_MASK};
    endfunction

    // ========================================
    // state

    logic [EVT_W-1:0]  mask_reg;
    logic [EVT_W-1:0]  mask_next;
    logic [EVT_W-1:0]  pending_reg;
    logic [EVT_W-1:0]  pending_next;
    logic              pready_reg;
    logic              pready_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              pslverr_reg;
    logic              pslverr_next;
    logic              irq_reg;
    logic              irq_next;

    // ========================================
    // address decode

    wire hit_mask_set      = (i_paddr == IRQ_MASK_SET_ADDR);
    wire hit_mask_clear    = (i_paddr == IRQ_MASK_CLEAR_ADDR);
    wire hit_mask_view     = (i_paddr == IRQ_MASK_VIEW_ADDR);
    wire hit_pending       = (i_paddr == IRQ_PENDING_ADDR);
    wire hit_pending_clear = (i_paddr == IRQ_PENDING_CLEAR_ADDR);
    wire hit_any           = hit_mask_set | hit_mask_clear | hit_mask_view
                           | hit_pending | hit_pending_clear;

    // ========================================
    // bus phases

    wire setup_phase  = i_psel & ~i_penable;
    wire access_done  = i_psel & i_penable & pready_reg;
    wire wr_done      = access_done & i_pwrite & hit_any;
    wire rd_done      = access_done & ~i_pwrite & hit_any;

    // only a full low lane carries the event bits
    wire lane0_ok     = i_pstrb[0];
    wire [EVT_W-1:0] wr_field = lane0_ok ? evt_field(i_pwdata) : {EVT_W{1'b0}};

    // ========================================
    // event inputs

    logic [EVT_W-1:0] evt_in;

    // events gathered at their register positions
    always_comb begin
        evt_in                    = '0;
        evt_in[LINE_EVT_BIT]      = i_line_evt;
        evt_in[LAST_LINE_EVT_BIT] = i_last_line_evt;
        evt_in[FRAME_END_BIT]     = i_frame_end;
        evt_in[FIFO_UNDER_BIT]    = i_fifo_under;
        evt_in[FIFO_OVERWR_BIT]   = i_fifo_overwr;
        evt_in[FETCH_ERR_BIT]     = i_fetch_err;
    end

    // ========================================
    // mask register

    wire [EVT_W-1:0] mask_set_bits = (wr_done & hit_mask_set) ? wr_field : {EVT_W{1'b0}};

    wire [EVT_W-1:0] mask_clr_bits = (wr_done & hit_mask_clear) ? wr_field : {EVT_W{1'b0}};

    assign mask_next = ((mask_reg & ~mask_clr_bits) | mask_set_bits) & EVT_FIELD_MASK;

    // ========================================
    // pending register

    wire [EVT_W-1:0] ack_bits = (wr_done & hit_pending_clear) ? wr_field : {EVT_W{1'b0}};

    // read clears only bits that were returned to software
    wire [EVT_W-1:0] rd_clr_bits = (rd_done & hit_pending) ? evt_field(prdata_reg)
                                                           : {EVT_W{1'b0}};

    wire [EVT_W-1:0] pend_clr_bits = ack_bits | rd_clr_bits;

    // per-bit sticky flags, new event wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_pend
            if (EVT_FIELD_MASK[gi]) begin : g_impl
                assign pending_next[gi] = evt_in[gi] | (pending_reg[gi] & ~pend_clr_bits[gi]);
            end else begin : g_rsvd
                assign pending_next[gi] = 1'b0;
            end
        end
    endgenerate

    // ========================================
    // interrupt request

    assign irq_next = |(pending_next & mask_next);

    // ========================================
    // read data and response

    wire [DATA_W-1:0] rd_mask_view = to_word(mask_reg);
    wire [DATA_W-1:0] rd_pending   = to_word(pending_reg);

    // write-only and reserved read as zero
    wire [DATA_W-1:0] rd_mux = hit_mask_view ? rd_mask_view :
                               hit_pending   ? rd_pending   :
                                               RDATA_RESET;

    // one wait-free access phase after each setup
    assign pready_next  = setup_phase;
    assign prdata_next  = setup_phase ? (i_pwrite ? RDATA_RESET : rd_mux)
                        : (access_done ? RDATA_RESET : prdata_reg);
    assign pslverr_next = setup_phase & ~hit_any;

    // ========================================
    // registers

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            mask_reg    <= MASK_RESET;
            pending_reg <= PENDING_RESET;
            irq_reg     <= 1'b0;
        end else begin
            mask_reg    <= mask_next;
            pending_reg <= pending_next;
            irq_reg     <= irq_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= RDATA_RESET;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ========================================
    // outputs

    assign o_pready  = pready_reg;
    assign o_prdata  = prdata_reg;
    assign o_pslverr = pslverr_reg;
    assign o_irq     = irq_reg;

endmodule

// ---- verification/lcd_irq_regs_sva.sv ----
`timescale 1ns/1ps
module lcd_irq_regs_sva
    import lcd_irq_pkg::*;
(
    input logic        i_clk,
    input logic        i_resetn,
    input logic        i_psel,
    input logic        i_penable,
    input logic        i_pwrite,
    input logic [31:0] i_paddr,
    input logic [31:0] i_pwdata,
    input logic [3:0]  i_pstrb,
    input logic        o_pready,
    input logic [31:0] o_prdata,
    input logic        o_pslverr,
    input logic        i_line_evt,
    input logic        i_last_line_evt,
    input logic        i_frame_end,
    input logic        i_fifo_under,
    input logic        i_fifo_overwr,
    input logic        i_fetch_err,
    input logic        o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // ====
    // shadow of the mask
    logic [6:0] evt, mask_reg, mask_next;
    logic       wr, rd, mapped;
    assign evt = {i_fetch_err, i_fifo_overwr, i_fifo_under, 1'b0, i_frame_end,
                  i_last_line_evt, i_line_evt};
    assign wr = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];
    assign rd = o_pready & !i_pwrite;
    assign mapped = i_paddr >= IRQ_MASK_SET_ADDR && i_paddr <= IRQ_PENDING_CLEAR_ADDR
                    && i_paddr[1:0] == 2'h0;
    assign mask_next = (wr && i_paddr == IRQ_MASK_SET_ADDR) ? mask_reg | (i_pwdata[6:0] & EVT_FIELD_MASK)
                     : (wr && i_paddr == IRQ_MASK_CLEAR_ADDR) ? mask_reg & ~i_pwdata[6:0] : mask_reg;
    always_ff @(posedge i_clk) mask_reg <= i_resetn ? mask_next : MASK_RESET;
    // ====
    // checks
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_pclr;
        wr && i_paddr == IRQ_PENDING_CLEAR_ADDR && (mask_reg & ~i_pwdata[6:0]) == 7'h00 && evt == 7'h00;
    endsequence
    a_ready_timing: assert property (s_setup |=> o_pready ##1 !o_pready) else $error("bad ready");
    a_err_unmapped: assert property (o_pready |-> o_pslverr == !mapped) else $error("bad slverr");
    a_view_value: assert property (rd && i_paddr == IRQ_MASK_VIEW_ADDR |-> o_prdata == {25'h0, mask_reg})
        else $error("bad mask view");
    a_rsvd_zero: assert property (o_pready |-> o_prdata[31:7] == 25'h0 && !o_prdata[3])
        else $error("reserved bits set");
    a_wo_zero: assert property (rd && (i_paddr == IRQ_MASK_SET_ADDR || i_paddr == IRQ_MASK_CLEAR_ADDR
        || i_paddr == IRQ_PENDING_CLEAR_ADDR) |-> o_prdata == 32'h0) else $error("wo read");
    a_evt_irq: assert property (|(evt & mask_reg) && !wr |=> o_irq) else $error("irq missing");
    a_irq_masked: assert property (mask_reg == 7'h00 |-> !o_irq) else $error("irq unmasked");
    a_pend_clear: assert property (s_pclr |=> !o_irq) else $error("clear failed");
endmodule

bind lcd_irq_regs lcd_irq_regs_sva i_sva (.*);

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
    import lcd_irq_pkg::*;
    logic        i_clk = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, o_prdata, r;
    logic [3:0]  i_pstrb = 4'hf;
    logic [6:0]  ev = 7'h00;
    logic        o_pready, o_pslverr, o_irq, e;
    int          miscompares = 0, tests_run = 0, cyc = 0;
    lcd_irq_regs i_dut (.*, .i_line_evt(ev[0]), .i_last_line_evt(ev[1]), .i_frame_end(ev[2]),
        .i_fifo_under(ev[4]), .i_fifo_overwr(ev[5]), .i_fetch_err(ev[6]));
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ====
    // bus tasks
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n = 0;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, x);
        apb(1'b0, a, 32'h0);
        `CHK({e, r}, {1'b0, x})
    endtask
    task automatic pulse(input logic [6:0] v);
        ev <= v;
        @(posedge i_clk);
        ev <= 7'h00;
        @(posedge i_clk);
    endtask
    // ====
    // scenarios
    task automatic t_mask;
        logic [31:0] m = 32'h0;
        for (int i = 0; i < 5; i++) rd(IRQ_MASK_SET_ADDR + 32'(4 * i), 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(IRQ_MASK_SET_ADDR, 32'h1 << i);
            m = m | ((32'h1 << i) & 32'h77);
            rd(IRQ_MASK_VIEW_ADDR, m);
        end
        wr(IRQ_MASK_SET_ADDR, 32'hffff_ff88);
        rd(IRQ_MASK_VIEW_ADDR, 32'h77);
        wr(IRQ_MASK_CLEAR_ADDR, 32'h40);
        rd(IRQ_MASK_VIEW_ADDR, 32'h37);
        wr(IRQ_MASK_CLEAR_ADDR, 32'h0);
        rd(IRQ_MASK_VIEW_ADDR, 32'h37);
        wr(IRQ_MASK_CLEAR_ADDR, 32'h37);
        rd(IRQ_MASK_VIEW_ADDR, 32'h0);
        $display("t_mask done");
    endtask
    task automatic t_pend;
        pulse(7'h7f);
        `CHK(o_irq, 1'b0)
        rd(IRQ_PENDING_ADDR, 32'h77);
        rd(IRQ_PENDING_ADDR, 32'h0);
        wr(IRQ_MASK_SET_ADDR, 32'h01);
        pulse(7'h41);
        `CHK(o_irq, 1'b1)
        wr(IRQ_PENDING_CLEAR_ADDR, 32'h01);
        `CHK(o_irq, 1'b0)
        rd(IRQ_PENDING_ADDR, 32'h40);
        pulse(7'h41);
        wr(IRQ_PENDING_CLEAR_ADDR, 32'h40);
        rd(IRQ_PENDING_ADDR, 32'h01);
        $display("t_pend done");
    endtask
    task automatic t_err;
        apb(1'b0, 32'h0060_085c, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0})
        wr(IRQ_MASK_VIEW_ADDR, 32'h77);
        wr(IRQ_PENDING_ADDR, 32'h77);
        i_pstrb <= 4'h0;
        wr(IRQ_MASK_SET_ADDR, 32'h77);
        i_pstrb <= 4'hf;
        rd(IRQ_MASK_VIEW_ADDR, 32'h01);
        rd(IRQ_PENDING_ADDR, 32'h0);
        $display("t_err done");
    endtask
    task automatic t_rst;
        wr(IRQ_MASK_SET_ADDR, 32'h77);
        pulse(7'h77);
        `CHK(o_irq, 1'b1)
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        `CHK(o_irq, 1'b0)
        rd(IRQ_MASK_VIEW_ADDR, 32'h0);
        rd(IRQ_PENDING_ADDR, 32'h0);
        $display("t_rst done");
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_mask();
        t_pend();
        t_err();
        t_rst();
        test_done();
    end
endmodule
